// *** hw/gdi_code_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module gdi_code_bank #(
  parameter int NUM = 15,
  parameter int CW = 10,
  parameter int AW = 6
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Asynchronous reset
  input wire logic clear_in, // Synchronous clear to reset codes
  input wire logic wr_en_in, // Write strobe
  input wire logic [AW-1:0] wr_addr_in, // Write address
  input wire logic [CW-1:0] wr_data_in, // Write code
  input wire logic [AW-1:0] rd_addr_in, // Read address
  output logic [CW-1:0] rd_data_out, // Read code, zero when unmapped
  output logic [NUM*CW-1:0] codes_out // All codes, register 0 lowest
);

  logic [CW-1:0] mem_r [NUM];
  logic [CW-1:0] mem_nxt [NUM];

  function automatic logic addr_hit(input logic [AW-1:0] a);
    addr_hit = (int'(a) < NUM);
  endfunction

  // ==========================================================================
  // Storage
  always_comb begin
    for (int i = 0; i < NUM; i++) begin
      mem_nxt[i] = mem_r[i];
      if (clear_in) begin
        mem_nxt[i] = gdi_pkg::CODE_RESET;
      end else if (wr_en_in && addr_hit(wr_addr_in) && (int'(wr_addr_in) == i)) begin
        mem_nxt[i] = wr_data_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM; i++) begin
        mem_r[i] <= gdi_pkg::CODE_RESET;
      end
    end else begin
      for (int i = 0; i < NUM; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

  // ==========================================================================
  // Read side
  always_comb begin
    rd_data_out = gdi_pkg::CODE_RESET;
    if (addr_hit(rd_addr_in)) begin
      rd_data_out = mem_r[rd_addr_in[$clog2(NUM)-1:0]];
    end
  end

  for (genvar g = 0; g < NUM; g++) begin : g_out
    assign codes_out[g*CW +: CW] = mem_r[g];
  end

endmodule
`default_nettype wire

// *** hw/gdi_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module gdi_pin_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] IDLE = '1
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Asynchronous reset
  input wire logic [W-1:0] pins_in, // Asynchronous pin levels
  output logic [W-1:0] sync_out, // Synchronised level
  output logic [W-1:0] prev_out // Synchronised level one cycle earlier
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;
  logic [W-1:0] prev_nxt;

  // ==========================================================================
  // Two stages plus one history stage for edge detection
  always_comb begin
    meta_nxt = pins_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= IDLE;
      sync_r <= IDLE;
      prev_r <= IDLE;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign sync_out = sync_r;
  assign prev_out = prev_r;

endmodule
`default_nettype wire

// *** hw/gdi_pkg.sv ***
package gdi_pkg;

  // ==========================================================================
  // Register file geometry
  localparam int CODE_W = 10;
  localparam int NUM_REGS = 15;
  localparam int NUM_GAMMA = 14;
  localparam int PTR_W = 6;
  localparam int BYTE_W = 8;
  localparam int CODE_HI_W = 2;
  localparam int DAC_FULL_SCALE_CODES = 1024;
  localparam logic [PTR_W-1:0] REF_REG_ADDR = 6'h00;
  localparam logic [PTR_W-1:0] FIRST_GAMMA_ADDR = 6'h01;
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam logic [PTR_W-1:0] PTR_STEP = 6'h01;
  localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;

  // ==========================================================================
  // Serial framing
  localparam logic [6:0] SLAVE_ADDR = 7'h74;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BIT_CNT_FIRST = 4'h1;
  localparam logic [3:0] BIT_CNT_STEP = 4'h1;
  localparam int CTRL_HI_BIT = 7;
  localparam int CTRL_LO_BIT = 6;
  localparam int PTR_LSB = 0;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

  // ==========================================================================
  // Synchroniser lanes
  localparam int SYNC_W = 5;
  localparam int LANE_SCL = 0;
  localparam int LANE_SDA = 1;
  localparam int LANE_UNDERVOLTAGE_LOCKOUT = 2;
  localparam int LANE_HOT = 3;
  localparam int LANE_COOL = 4;
  // Bus lanes idle high, status lanes idle low, so reset shows no false edge or trip
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h03;

  // ==========================================================================
  // Serial engine states
  typedef enum logic [2:0] {
    GDI_IDLE,
    GDI_ADDR,
    GDI_PTR,
    GDI_WDATA,
    GDI_ACK,
    GDI_RDATA,
    GDI_RACK,
    GDI_WAIT
  } gdi_state_t;

endpackage

// *** hw/gdi_port.sv ***
// Functional notes
// - Each gamma output is reference times its code over 1024; code tops at 1023.
// - Reset and undervoltage lockout force every register to a known state.
// - Outputs stay high impedance in safe mode until a valid write arrives.
// - Die over temperature disables outputs; re-enabled only after cooling by hysteresis.
// - One bit per SCL cycle; SDA changes while SCL high are conditions.
// - SDA fall with SCL high is START; SDA rise with SCL high is STOP.
// - STOP honoured anywhere except in the same SCL high pulse as START.
// - Device pulls SDA low through the whole ninth pulse of written bytes.
// - First byte is 7-bit address plus direction; E8h writes, E9h reads.
// - Each access moves a two-byte word; ten low bits are stored.
// - Write ignored unless word bits 15 and 14 are both zero.
// - Pointer byte low six bits load the register pointer; byte acknowledged.
// - Pointer advances by one after each complete received word.
// - Read returns words from the pointer, advancing after every two bytes.
// - STOP leaves the register pointer unchanged.
// - Low eight code bits go in the low byte, top two in high byte.
// - Register zero sets the full-scale reference as 10 V times code over 1024.
`timescale 1ns/1ps
`default_nettype none

module gdi_port #(
  parameter int NUM_REGS = gdi_pkg::NUM_REGS,
  parameter int CODE_W = gdi_pkg::CODE_W
) (
  input wire logic clk_in, // 125 MHz system clock
  input wire logic rst_in, // Power-on reset, async, active high
  input wire logic scl_in, // Serial clock pin
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive level, always low
  output logic sda_oe_out, // High while pulling SDA low
  input wire logic undervoltage_lockout_in, // High while digital supply is below threshold
  input wire logic thermal_hot_in, // High when die reaches trip temperature
  input wire logic thermal_cool_in, // High when die has cooled by the hysteresis
  output logic [CODE_W-1:0] reference_code_out, // Full-scale reference code
  output logic [(NUM_REGS-1)*CODE_W-1:0] gamma_code_out, // Gamma codes, channel one lowest
  output logic gamma_output_enable_out, // High when gamma outputs drive
  output logic safe_mode_out, // High while in protective safe mode
  output logic thermal_shutdown_out // High while thermally shut down
);

  // ==========================================================================
  // Pin synchronisers and bus conditions
  logic [gdi_pkg::SYNC_W-1:0] pins;
  logic [gdi_pkg::SYNC_W-1:0] pin_s;
  logic [gdi_pkg::SYNC_W-1:0] pin_p;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic undervoltage_lockout_s;
  logic hot_s;
  logic cool_s;

  assign pins = {thermal_cool_in, thermal_hot_in, undervoltage_lockout_in, sda_in, scl_in};

  gdi_pin_sync #(
    .W(gdi_pkg::SYNC_W),
    .IDLE(gdi_pkg::SYNC_IDLE)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in(pins),
    .sync_out(pin_s),
    .prev_out(pin_p)
  );

  assign scl_rise = pin_s[gdi_pkg::LANE_SCL] & ~pin_p[gdi_pkg::LANE_SCL];
  assign scl_fall = ~pin_s[gdi_pkg::LANE_SCL] & pin_p[gdi_pkg::LANE_SCL];
  assign start_cond = pin_s[gdi_pkg::LANE_SCL] & pin_p[gdi_pkg::LANE_SCL]
                    & pin_p[gdi_pkg::LANE_SDA] & ~pin_s[gdi_pkg::LANE_SDA];
  assign stop_cond = pin_s[gdi_pkg::LANE_SCL] & pin_p[gdi_pkg::LANE_SCL]
                   & ~pin_p[gdi_pkg::LANE_SDA] & pin_s[gdi_pkg::LANE_SDA];
  assign undervoltage_lockout_s = pin_s[gdi_pkg::LANE_UNDERVOLTAGE_LOCKOUT];
  assign hot_s = pin_s[gdi_pkg::LANE_HOT];
  assign cool_s = pin_s[gdi_pkg::LANE_COOL];

  // ==========================================================================
  // Code registers
  logic wr_en;
  logic [CODE_W-1:0] wr_data;
  logic [CODE_W-1:0] rd_data;
  logic [NUM_REGS*CODE_W-1:0] codes;
  logic [gdi_pkg::PTR_W-1:0] ptr_r;
  logic [gdi_pkg::PTR_W-1:0] ptr_nxt;

  gdi_code_bank #(
    .NUM(NUM_REGS),
    .CW(CODE_W),
    .AW(gdi_pkg::PTR_W)
  ) u_bank (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(undervoltage_lockout_s),
    .wr_en_in(wr_en),
    .wr_addr_in(ptr_r),
    .wr_data_in(wr_data),
    .rd_addr_in(ptr_r),
    .rd_data_out(rd_data),
    .codes_out(codes)
  );

  // Register zero feeds the reference DAC, the rest feed the gamma DACs
  assign reference_code_out = codes[0 +: CODE_W];
  assign gamma_code_out = codes[CODE_W +: (NUM_REGS-1)*CODE_W];

  // High byte carries the top two code bits, low byte the bottom eight
  function automatic logic [gdi_pkg::BYTE_W-1:0] word_byte(input logic low_sel,
                                                          input logic [CODE_W-1:0] code);
    if (low_sel) begin
      word_byte = code[gdi_pkg::BYTE_W-1:0];
    end else begin
      word_byte = {{(gdi_pkg::BYTE_W-gdi_pkg::CODE_HI_W){1'b0}},
                   code[CODE_W-1:gdi_pkg::BYTE_W]};
    end
  endfunction

  // ==========================================================================
  // Serial engine
  gdi_pkg::gdi_state_t state_r;
  gdi_pkg::gdi_state_t state_nxt;
  gdi_pkg::gdi_state_t after_r;
  gdi_pkg::gdi_state_t after_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [gdi_pkg::BYTE_W-1:0] shift_r;
  logic [gdi_pkg::BYTE_W-1:0] shift_nxt;
  logic [gdi_pkg::BYTE_W-1:0] msb_r;
  logic [gdi_pkg::BYTE_W-1:0] msb_nxt;
  logic [gdi_pkg::BYTE_W-1:0] tx_r;
  logic [gdi_pkg::BYTE_W-1:0] tx_nxt;
  logic low_sel_r;
  logic low_sel_nxt;
  logic oe_r;
  logic oe_nxt;
  logic start_hold_r;
  logic start_hold_nxt;
  logic mack_r;
  logic mack_nxt;
  logic [gdi_pkg::BYTE_W-1:0] load_byte;

  always_comb begin
    state_nxt = state_r;
    after_nxt = after_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    msb_nxt = msb_r;
    tx_nxt = tx_r;
    low_sel_nxt = low_sel_r;
    oe_nxt = oe_r;
    start_hold_nxt = start_hold_r;
    mack_nxt = mack_r;
    ptr_nxt = ptr_r;
    wr_en = 1'b0;
    wr_data = {msb_r[gdi_pkg::CODE_HI_W-1:0], shift_r};
    load_byte = word_byte(low_sel_r, rd_data);
    if (undervoltage_lockout_s) begin
      state_nxt = gdi_pkg::GDI_IDLE;
      ptr_nxt = gdi_pkg::PTR_RESET;
      oe_nxt = 1'b0;
      low_sel_nxt = 1'b0;
      start_hold_nxt = 1'b0;
    end else if (start_cond) begin
      state_nxt = gdi_pkg::GDI_ADDR;
      cnt_nxt = gdi_pkg::BIT_CNT_RESET;
      oe_nxt = 1'b0;
      start_hold_nxt = 1'b1;
    end else if (stop_cond && !start_hold_r) begin
      state_nxt = gdi_pkg::GDI_IDLE;
      oe_nxt = 1'b0;
    end else begin
      if (scl_fall) begin
        start_hold_nxt = 1'b0;
      end
      case (state_r)
        gdi_pkg::GDI_ADDR, gdi_pkg::GDI_PTR, gdi_pkg::GDI_WDATA: begin
          if (scl_rise && (cnt_r < gdi_pkg::BITS_PER_BYTE)) begin
            shift_nxt = {shift_r[gdi_pkg::BYTE_W-2:0], pin_s[gdi_pkg::LANE_SDA]};
            cnt_nxt = cnt_r + gdi_pkg::BIT_CNT_STEP;
          end else if (scl_fall && (cnt_r == gdi_pkg::BITS_PER_BYTE)) begin
            cnt_nxt = gdi_pkg::BIT_CNT_RESET;
            state_nxt = gdi_pkg::GDI_ACK;
            oe_nxt = 1'b1;
            if (state_r == gdi_pkg::GDI_ADDR) begin
              low_sel_nxt = 1'b0;
              if (shift_r[gdi_pkg::BYTE_W-1:1] == gdi_pkg::SLAVE_ADDR) begin
                after_nxt = (shift_r[0] == gdi_pkg::DIR_READ) ? gdi_pkg::GDI_RDATA
                                                                : gdi_pkg::GDI_PTR;
              end else begin
                state_nxt = gdi_pkg::GDI_WAIT;
                oe_nxt = 1'b0;
              end
            end else if (state_r == gdi_pkg::GDI_PTR) begin
              ptr_nxt = shift_r[gdi_pkg::PTR_LSB +: gdi_pkg::PTR_W];
              low_sel_nxt = 1'b0;
              after_nxt = gdi_pkg::GDI_WDATA;
            end else begin
              after_nxt = gdi_pkg::GDI_WDATA;
              if (!low_sel_r) begin
                msb_nxt = shift_r;
                low_sel_nxt = 1'b1;
              end else begin
                wr_en = ~msb_r[gdi_pkg::CTRL_HI_BIT] & ~msb_r[gdi_pkg::CTRL_LO_BIT];
                ptr_nxt = ptr_r + gdi_pkg::PTR_STEP;
                low_sel_nxt = 1'b0;
              end
            end
          end
        end
        gdi_pkg::GDI_ACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            state_nxt = after_r;
            if (after_r == gdi_pkg::GDI_RDATA) begin
              tx_nxt = load_byte;
              oe_nxt = ~load_byte[gdi_pkg::BYTE_W-1];
              cnt_nxt = gdi_pkg::BIT_CNT_FIRST;
            end
          end
        end
        gdi_pkg::GDI_RDATA: begin
          if (scl_fall) begin
            if (cnt_r < gdi_pkg::BITS_PER_BYTE) begin
              tx_nxt = {tx_r[gdi_pkg::BYTE_W-2:0], 1'b0};
              oe_nxt = ~tx_r[gdi_pkg::BYTE_W-2];
              cnt_nxt = cnt_r + gdi_pkg::BIT_CNT_STEP;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = gdi_pkg::GDI_RACK;
              low_sel_nxt = ~low_sel_r;
              if (low_sel_r) begin
                ptr_nxt = ptr_r + gdi_pkg::PTR_STEP;
              end
            end
          end
        end
        gdi_pkg::GDI_RACK: begin
          if (scl_rise) begin
            mack_nxt = ~pin_s[gdi_pkg::LANE_SDA];
          end else if (scl_fall) begin
            if (mack_r) begin
              state_nxt = gdi_pkg::GDI_RDATA;
              tx_nxt = load_byte;
              oe_nxt = ~load_byte[gdi_pkg::BYTE_W-1];
              cnt_nxt = gdi_pkg::BIT_CNT_FIRST;
            end else begin
              state_nxt = gdi_pkg::GDI_WAIT;
            end
          end
        end
        gdi_pkg::GDI_IDLE, gdi_pkg::GDI_WAIT: begin
          oe_nxt = 1'b0;
        end
        default: begin
          state_nxt = gdi_pkg::GDI_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= gdi_pkg::GDI_IDLE;
      after_r <= gdi_pkg::GDI_IDLE;
      cnt_r <= gdi_pkg::BIT_CNT_RESET;
      shift_r <= gdi_pkg::BYTE_RESET;
      msb_r <= gdi_pkg::BYTE_RESET;
      tx_r <= gdi_pkg::BYTE_RESET;
      low_sel_r <= 1'b0;
      oe_r <= 1'b0;
      start_hold_r <= 1'b0;
      mack_r <= 1'b0;
      ptr_r <= gdi_pkg::PTR_RESET;
    end else begin
      state_r <= state_nxt;
      after_r <= after_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      msb_r <= msb_nxt;
      tx_r <= tx_nxt;
      low_sel_r <= low_sel_nxt;
      oe_r <= oe_nxt;
      start_hold_r <= start_hold_nxt;
      mack_r <= mack_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  // ==========================================================================
  // Output protection
  logic safe_r;
  logic safe_nxt;
  logic therm_r;
  logic therm_nxt;
  logic en_r;
  logic en_nxt;
  logic sda_lvl_r;
  logic sda_lvl_nxt;

  always_comb begin
    safe_nxt = safe_r;
    therm_nxt = therm_r;
    sda_lvl_nxt = 1'b0;
    if (undervoltage_lockout_s) begin
      safe_nxt = 1'b1;
    end else if (wr_en) begin
      safe_nxt = 1'b0;
    end
    if (hot_s) begin
      therm_nxt = 1'b1;
    end else if (cool_s) begin
      therm_nxt = 1'b0;
    end
    en_nxt = ~safe_nxt & ~therm_nxt;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      safe_r <= 1'b1;
      therm_r <= 1'b0;
      en_r <= 1'b0;
      sda_lvl_r <= 1'b0;
    end else begin
      safe_r <= safe_nxt;
      therm_r <= therm_nxt;
      en_r <= en_nxt;
      sda_lvl_r <= sda_lvl_nxt;
    end
  end

  assign sda_out = sda_lvl_r;
  assign sda_oe_out = oe_r;
  assign gamma_output_enable_out = en_r;
  assign safe_mode_out = safe_r;
  assign thermal_shutdown_out = therm_r;

endmodule
`default_nettype wire

// *** tb/gamma_dac_i2c_register_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module gamma_dac_i2c_register_port_bench;
  localparam int NR = gdi_pkg::NUM_REGS;
  localparam int CW = gdi_pkg::CODE_W;
  logic clk_in, rst_in, scl, mst_pull, undervoltage_lockout, hot, cool, sda_line, sda_out, sda_oe_out, gamma_en, safe, tsd;
  logic [CW-1:0] ref_code;
  logic [(NR-1)*CW-1:0] gamma;
  logic [NR*CW-1:0] bank;
  logic [CW-1:0] exp_r [NR];
  int fails = 0, samples_checked = 0, cyc = 0;
  // Die temperature model drives both thermal comparators
  localparam int TRIP_C = 165;
  localparam int HYST_C = 15;
  int temp_c = 25;
  assign hot = (temp_c >= TRIP_C);
  assign cool = (temp_c <= TRIP_C - HYST_C);
  // Open-drain wire with pull-up
  assign sda_line = !(mst_pull || (sda_oe_out && !sda_out));
  assign bank = {gamma, ref_code};
  gdi_port i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .undervoltage_lockout_in(undervoltage_lockout), .thermal_hot_in(hot), .thermal_cool_in(cool), .reference_code_out(ref_code),
    .gamma_code_out(gamma), .gamma_output_enable_out(gamma_en), .safe_mode_out(safe), .thermal_shutdown_out(tsd)
  );
  gdi_i2c_master i_mst (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl), .sda_pull_out(mst_pull));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = !clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bank();
    for (int i = 0; i < NR; i++) chk("code", 16'(exp_r[i]), 16'(bank[i*CW +: CW]));
  endtask
  task automatic send(input logic [7:0] b, input logic ack_exp);
    logic a;
    i_mst.byte_wr(b, a);
    chk("ack", 16'(ack_exp), 16'(a));
  endtask
  task automatic wr_frame(input logic [5:0] ptr, input logic [15:0] w[$]);
    i_mst.start();
    send(8'he8, 1'b1);
    send({2'b11, ptr}, 1'b1);
    foreach (w[k]) begin
      send(w[k][15:8], 1'b1);
      send(w[k][7:0], 1'b1);
    end
    i_mst.stop();
    i_mst.tick(4);
  endtask
  task automatic rd_frame(input logic set, input logic [5:0] ptr, input int n, input int first);
    logic [7:0] hi, lo;
    i_mst.start();
    if (set) begin
      send(8'he8, 1'b1);
      send({2'b00, ptr}, 1'b1);
      i_mst.start();
    end
    send(8'he9, 1'b1);
    for (int k = 0; k < n; k++) begin
      i_mst.byte_rd(1'b0, hi);
      i_mst.byte_rd(k == n - 1, lo);
      chk("read", 16'(exp_r[first+k]), {hi, lo});
    end
    i_mst.stop();
  endtask
  task automatic t_fill();
    logic [15:0] w[$];
    chk_bank();
    chk("safe", 16'h1, 16'(safe));
    for (int i = 0; i < NR; i++) begin
      exp_r[i] = 10'h3ff - 10'(i * 'h45);
      w.push_back({6'b001111, exp_r[i]});
    end
    wr_frame(6'h00, w);
    chk_bank();
    chk("safe", 16'h0, 16'(safe));
    chk("enable", 16'h1, 16'(gamma_en));
    $display("test fill done");
  endtask
  task automatic t_ctrl();
    logic [15:0] w[$];
    w = '{16'h8123, 16'h4123, 16'hc123, 16'h0123};
    exp_r[6] = 10'h123;
    wr_frame(6'h03, w);
    chk_bank();
    $display("test control bits done");
  endtask
  task automatic t_read();
    rd_frame(1'b1, 6'h02, 3, 2);
    rd_frame(1'b0, 6'h00, 2, 5);
    $display("test read done");
  endtask
  task automatic t_thermal();
    temp_c = TRIP_C + 5;
    i_mst.tick(8);
    chk("shutdown", 16'h1, 16'(tsd));
    temp_c = TRIP_C - HYST_C + 5;
    i_mst.tick(8);
    chk("held", 16'h1, 16'(tsd));
    chk("enable", 16'h0, 16'(gamma_en));
    temp_c = TRIP_C - HYST_C - 10;
    i_mst.tick(8);
    chk("enable", 16'h1, 16'(gamma_en));
    temp_c = 25;
    $display("test thermal done");
  endtask
  task automatic t_addr();
    i_mst.start();
    send(8'he6, 1'b0);
    i_mst.stop();
    chk_bank();
    $display("test address done");
  endtask
  task automatic t_undervoltage_lockout();
    undervoltage_lockout = 1'b1;
    i_mst.tick(8);
    for (int i = 0; i < NR; i++) exp_r[i] = '0;
    chk_bank();
    chk("safe", 16'h1, 16'(safe));
    undervoltage_lockout = 1'b0;
    $display("test lockout done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    undervoltage_lockout = 1'b0;
    for (int i = 0; i < NR; i++) exp_r[i] = '0;
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    i_mst.tick(3);
    t_fill();
    t_thermal();
    t_ctrl();
    t_read();
    t_addr();
    t_undervoltage_lockout();
    summarize();
  end
endmodule
`default_nettype wire

// *** tb/gdi_i2c_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdi_i2c_master (
  input wire logic clk_in, // System clock
  input wire logic sda_in, // Resolved SDA wire
  output logic scl_out, // SCL level
  output logic sda_pull_out // High while pulling SDA low
);
  localparam int HALF = 5;
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Works from idle and, as a repeated start, with SCL low
  task automatic start();
    sda_pull_out = 1'b0;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_pull_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
    tick(3);
  endtask
  task automatic stop();
    sda_pull_out = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_pull_out = 1'b0;
    tick(HALF);
  endtask
  // Data set while SCL low and held past the falling edge
  task automatic bit_io(input logic b, output logic s);
    sda_pull_out = !b;
    tick(HALF);
    scl_out = 1'b1;
    tick(3);
    s = sda_in;
    tick(2);
    scl_out = 1'b0;
    tick(3);
  endtask
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic byte_rd(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, s);
  endtask
endmodule
`default_nettype wire

// *** tb/gdi_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module gdi_port_props #(
  parameter int NUM_REGS = 15,
  parameter int CODE_W = 10
) (
  input wire logic clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic scl_in, // SCL pin
  input wire logic sda_in, // SDA wire
  input wire logic sda_out, // SDA drive level
  input wire logic sda_oe_out, // SDA pull enable
  input wire logic undervoltage_lockout_in, // Supply low
  input wire logic thermal_hot_in, // Trip comparator
  input wire logic thermal_cool_in, // Cooled comparator
  input wire logic [CODE_W-1:0] reference_code_out, // Reference code
  input wire logic [(NUM_REGS-1)*CODE_W-1:0] gamma_code_out, // Gamma codes
  input wire logic gamma_output_enable_out, // Output enable
  input wire logic safe_mode_out, // Safe mode
  input wire logic thermal_shutdown_out // Shutdown
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic any_code;
  // A clear leaves every code zero, so a nonzero change can only be a store
  assign any_code = (gamma_code_out != '0) || (reference_code_out != '0);
  drive_low_a: assert property (sda_oe_out |-> !sda_out) else $error("sda driven high");
  ack_hold_a: assert property ($rose(sda_oe_out) |-> sda_oe_out[*8]) else $error("sda pull too short");
  oe_scl_low_a: assert property (!$stable(sda_oe_out) |-> !scl_in) else $error("sda moved, scl high");
  en_follow_a: assert property (gamma_output_enable_out == (!safe_mode_out && !thermal_shutdown_out))
    else $error("enable wrong");
  hot_trip_a: assert property (thermal_hot_in[*5] |-> thermal_shutdown_out) else $error("no shutdown");
  cool_clear_a: assert property ((thermal_cool_in && !thermal_hot_in)[*5] |-> !thermal_shutdown_out)
    else $error("shutdown stuck");
  hyst_hold_a: assert property ($fell(thermal_shutdown_out) |-> $past(thermal_cool_in, 2))
    else $error("left shutdown while hot");
  store_safe_a: assert property ((!$stable(gamma_code_out) || !$stable(reference_code_out)) && any_code
    |-> ##[0:2] !safe_mode_out) else $error("safe mode kept");
  store_ack_a: assert property ((!$stable(gamma_code_out) || !$stable(reference_code_out)) && any_code
    |-> ##[0:2] sda_oe_out) else $error("store outside ack");
  undervoltage_lockout_clear_a: assert property (undervoltage_lockout_in[*6] |-> !any_code && safe_mode_out
    && !gamma_output_enable_out) else $error("lockout did not clear");
  cover property ($fell(safe_mode_out));
  cover property ($rose(thermal_shutdown_out));
  cover property ($rose(sda_oe_out) ##1 scl_in);
endmodule
bind gdi_port gdi_port_props #(.NUM_REGS(NUM_REGS), .CODE_W(CODE_W)) i_props (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .undervoltage_lockout_in(undervoltage_lockout_in), .thermal_hot_in(thermal_hot_in),
  .thermal_cool_in(thermal_cool_in), .reference_code_out(reference_code_out), .gamma_code_out(gamma_code_out),
  .gamma_output_enable_out(gamma_output_enable_out), .safe_mode_out(safe_mode_out),
  .thermal_shutdown_out(thermal_shutdown_out)
);
`default_nettype wire
